/* File: rtl/udcfg_consts.svh */
// Purpose: constants for the device-side interrupt mask and DMA setup registers
// Assumes: command-code register access, 16-bit data words
// Notes: command codes, setup fields and the mask, setup and count reset values live here
`ifndef UDCFG_CONSTS_SVH
`define UDCFG_CONSTS_SVH
`define UDCFG_CMD_SETUP_WR 8'hf0
`define UDCFG_CMD_SETUP_RD 8'hf1
`define UDCFG_CMD_COUNT_WR 8'hf2
`define UDCFG_CMD_COUNT_RD 8'hf3
`define UDCFG_CMD_MASK_WR 8'hc2
`define UDCFG_CMD_MASK_RD 8'hc3
`define UDCFG_MASK_RESET 32'h0000_0000
`define UDCFG_MASK_WMASK 32'h00ff_ff7f
`define UDCFG_SETUP_RESET 16'h0000
`define UDCFG_SETUP_WMASK 16'hc0fb
`define UDCFG_BIT_CNT_END 15
`define UDCFG_BIT_SHORT 14
`define UDCFG_BIT_RUN 3
`define UDCFG_EP_LSB 4
`define UDCFG_EP_MSB 7
`define UDCFG_BURST_LSB 0
`define UDCFG_BURST_MSB 1
`define UDCFG_COUNT_RESET 16'h0000
`define UDCFG_NUM_EVENTS 24
`endif

/* File: rtl/udcfg_pkg.sv */
// Purpose: types for the interrupt mask and DMA setup block
// Assumes: constants come from udcfg_consts.svh
// Notes: bus phase states for the command port
package udcfg_pkg;
   typedef enum logic [1:0] {UDCFG_IDLE, UDCFG_LO, UDCFG_HI} udcfg_phase_t;
   typedef enum logic [1:0] {UDCFG_B1, UDCFG_B4, UDCFG_B8, UDCFG_B16} udcfg_burst_t;
endpackage

/* File: rtl/udcfg_regs.sv */
// Purpose: interrupt mask and DMA setup registers behind the command port
// Assumes: cmd_valid/wr_valid/rd_take are one-cycle strobes from local logic
// Notes: the 32-bit mask moves as two words, low first; others one word
`include "udcfg_consts.svh"
module udcfg_regs
   import udcfg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Command port
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic wr_valid,
   input wire logic [15:0] wr_data,
   input wire logic rd_take,
   output logic [15:0] rd_data,
   // Controller events and status
   input wire logic usb_bus_reset,
   input wire logic [23:0] event_pulse,
   input wire logic count_step,
   input wire logic short_out_packet,
   // Outputs
   output logic irq_req,
   output logic [23:0] event_status,
   output logic dma_active,
   output logic [3:0] dma_target_endpoint,
   output logic [1:0] burst_length_sel,
   output logic end_of_transfer
);
   logic rst_meta, rst_sync, rst_n;
   udcfg_phase_t phase;
   logic [7:0] cur_cmd;
   logic [31:0] interrupt_mask;
   logic [15:0] dma_setup, dma_count_reg, dma_byte_count;
   logic run_set, run_clr;
   logic [15:0] next_rd;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end
   assign rst_n = rst_sync;

   // Command phase tracking; a new command always restarts the sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= UDCFG_IDLE;
         cur_cmd <= 8'h00;
      end else if (cmd_valid) begin
         phase <= UDCFG_LO;
         cur_cmd <= cmd_code;
      end else if (wr_valid || rd_take) begin
         case (phase)
            UDCFG_LO: phase <= (cur_cmd[7:1] == 7'h61) ? UDCFG_HI : UDCFG_IDLE;
            UDCFG_HI: phase <= UDCFG_IDLE;
            default: phase <= UDCFG_IDLE;
         endcase
      end
   end

   // Reserved mask bits forced to zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         interrupt_mask <= `UDCFG_MASK_RESET;
      else if (wr_valid && cur_cmd == `UDCFG_CMD_MASK_WR && phase == UDCFG_LO)
         interrupt_mask[15:0] <= wr_data & 16'(`UDCFG_MASK_WMASK);
      else if (wr_valid && cur_cmd == `UDCFG_CMD_MASK_WR && phase == UDCFG_HI)
         interrupt_mask[31:16] <= wr_data & 16'(`UDCFG_MASK_WMASK >> 16);
   end

   assign run_set = wr_valid && cur_cmd == `UDCFG_CMD_SETUP_WR && phase == UDCFG_LO
                    && wr_data[`UDCFG_BIT_RUN];
   assign run_clr = wr_valid && cur_cmd == `UDCFG_CMD_SETUP_WR && phase == UDCFG_LO
                    && !wr_data[`UDCFG_BIT_RUN];

   // Bus reset clears only run; ending stops run too
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         dma_setup <= `UDCFG_SETUP_RESET;
      else if (wr_valid && cur_cmd == `UDCFG_CMD_SETUP_WR && phase == UDCFG_LO)
         dma_setup <= (wr_data & `UDCFG_SETUP_WMASK) & ~({15'h0000, usb_bus_reset} << `UDCFG_BIT_RUN);
      else if (usb_bus_reset || end_of_transfer)
         dma_setup[`UDCFG_BIT_RUN] <= 1'b0;
   end

   // Programmed count keeps its value over bus reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         dma_count_reg <= `UDCFG_COUNT_RESET;
      else if (wr_valid && cur_cmd == `UDCFG_CMD_COUNT_WR && phase == UDCFG_LO)
         dma_count_reg <= wr_data;
   end

   // Reload on each enable; counts down while running
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         dma_byte_count <= `UDCFG_COUNT_RESET;
      else if (run_set && !usb_bus_reset)
         dma_byte_count <= dma_count_reg;
      else if (dma_setup[`UDCFG_BIT_RUN] && count_step && dma_byte_count != 16'h0000)
         dma_byte_count <= dma_byte_count - 16'h0001;
   end

   // End of transfer pulse; software keeps short mode off for IN
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         end_of_transfer <= 1'b0;
      else
         end_of_transfer <= dma_setup[`UDCFG_BIT_RUN] && !end_of_transfer && !run_clr && !usb_bus_reset &&
            ((dma_setup[`UDCFG_BIT_CNT_END] && dma_byte_count == 16'h0000) ||
             (dma_setup[`UDCFG_BIT_SHORT] && short_out_packet));
   end

   // Status always records; set wins over a read-clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         event_status <= 24'h000000;
      else
         event_status <= event_pulse |
            ((rd_take && cur_cmd == `UDCFG_CMD_MASK_RD) ? 24'h000000 : event_status) & 24'hffffff;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         irq_req <= 1'b0;
      else
         irq_req <= |(event_status & interrupt_mask[23:0]);
   end

   always_comb begin
      next_rd = 16'h0000;
      case (cur_cmd)
         `UDCFG_CMD_SETUP_RD: next_rd = dma_setup;
         `UDCFG_CMD_COUNT_RD: next_rd = dma_byte_count;
         `UDCFG_CMD_MASK_RD: next_rd = (phase == UDCFG_HI) ? interrupt_mask[31:16] : interrupt_mask[15:0];
         default: next_rd = 16'h0000;
      endcase
   end

   // Registered read data and field outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 16'h0000;
         dma_active <= 1'b0;
         dma_target_endpoint <= 4'h0;
         burst_length_sel <= 2'h0;
      end else begin
         rd_data <= next_rd;
         dma_active <= dma_setup[`UDCFG_BIT_RUN] && !run_clr && !usb_bus_reset && !end_of_transfer;
         dma_target_endpoint <= dma_setup[`UDCFG_EP_MSB:`UDCFG_EP_LSB];
         burst_length_sel <= dma_setup[`UDCFG_BURST_MSB:`UDCFG_BURST_LSB];
      end
   end

   // Checks
   AST_MASK_RSVD: assert property (@(posedge clk) disable iff (!rst_n)
      interrupt_mask[31:24] == 8'h00 && !interrupt_mask[7]) else $error("reserved mask bits set");
   AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!rst_n)
      ((event_status & interrupt_mask[23:0]) == 24'h0) |=> !irq_req) else $error("irq without enable");
   AST_IRQ_FIRE: assert property (@(posedge clk) disable iff (!rst_n)
      ((event_status & interrupt_mask[23:0]) != 24'h0) |=> irq_req) else $error("enabled event no irq");
   AST_STATUS_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      event_pulse != 24'h0 |=> (event_status & $past(event_pulse)) == $past(event_pulse))
      else $error("event lost");
   AST_BUSRST_RUN: assert property (@(posedge clk) disable iff (!rst_n)
      usb_bus_reset |=> !dma_setup[`UDCFG_BIT_RUN] ##1 !dma_active) else $error("run survived bus reset");
   AST_BUSRST_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      usb_bus_reset && !wr_valid |=> dma_setup[15:4] == $past(dma_setup[15:4])) else $error("bus reset hit fields");
   AST_RUN_STOP: assert property (@(posedge clk) disable iff (!rst_n)
      run_clr |=> !dma_setup[`UDCFG_BIT_RUN] && !dma_active) else $error("stop not immediate");
   AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
      run_set && !usb_bus_reset |=> dma_byte_count == $past(dma_count_reg)) else $error("no reload");
   AST_CNT_EOT: assert property (@(posedge clk) disable iff (!rst_n)
      dma_setup[15] && dma_setup[3] && dma_byte_count == 16'h0 && !end_of_transfer && !usb_bus_reset
      && !wr_valid |=> end_of_transfer) else $error("no count end");
   AST_SHORT_EOT: assert property (@(posedge clk) disable iff (!rst_n)
      dma_setup[14] && dma_setup[3] && short_out_packet && !end_of_transfer && !usb_bus_reset
      && !wr_valid |=> end_of_transfer) else $error("no short end");
   AST_EOT_RUN: assert property (@(posedge clk) disable iff (!rst_n)
      end_of_transfer |-> $past(dma_setup[3])) else $error("end without run");
   AST_SETUP_RD: assert property (@(posedge clk) disable iff (!rst_n)
      cur_cmd == `UDCFG_CMD_SETUP_RD && !wr_valid && !usb_bus_reset && !end_of_transfer
      |=> rd_data == $past(dma_setup)) else $error("setup read wrong");
   AST_FIELDS: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 dma_target_endpoint == $past(dma_setup[7:4]) && burst_length_sel == $past(dma_setup[1:0]))
      else $error("field output stale");
   AST_COUNT_RD: assert property (@(posedge clk) disable iff (!rst_n)
      cur_cmd == `UDCFG_CMD_COUNT_RD |=> rd_data == $past(dma_byte_count)) else $error("count read wrong");
   AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!rst_n)
      dma_setup[3] && count_step && dma_byte_count != 16'h0 && !run_set
      |=> dma_byte_count == $past(dma_byte_count) - 16'h0001) else $error("count not stepped");
   AST_EOT_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
      end_of_transfer |=> !end_of_transfer) else $error("end pulse too long");
   // Mask only moves on its own write command, so stray data words cannot open an interrupt
   AST_MASK_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      !(wr_valid && cur_cmd == `UDCFG_CMD_MASK_WR) |=> $stable(interrupt_mask)) else $error("mask moved");

   for (genvar i = 0; i < `UDCFG_NUM_EVENTS; i++) begin : g_evt
      AST_EVT_SET: assert property (@(posedge clk) disable iff (!rst_n)
         event_pulse[i] |=> event_status[i]) else $error("event not recorded");
      AST_EVT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
         event_status[i] && !(rd_take && cur_cmd == `UDCFG_CMD_MASK_RD) |=> event_status[i])
         else $error("status bit dropped");
   end

   // Main scenarios that the bench should reach
   COV_RUN: cover property (@(posedge clk) disable iff (!rst_n) run_set ##[1:50] end_of_transfer);
   COV_IRQ: cover property (@(posedge clk) disable iff (!rst_n) !irq_req ##1 irq_req);
   COV_BUSRST: cover property (@(posedge clk) disable iff (!rst_n) dma_active ##1 usb_bus_reset);
   COV_SHORT: cover property (@(posedge clk) disable iff (!rst_n)
      dma_setup[14] && short_out_packet ##1 end_of_transfer);
   COV_STATUS_CLR: cover property (@(posedge clk) disable iff (!rst_n)
      event_status != 24'h0 ##1 event_status == 24'h0);
endmodule

/* File: verification/udcfg_host.sv */
// Purpose: host model issuing register commands
// Assumes: strobes move 1 ns after clk rises
// Notes: idle lines carry junk so stale data never matches
module udcfg_host (
   // Clock
   input wire logic clk,
   // Command port
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic wr_valid,
   output logic [15:0] wr_data,
   output logic rd_take,
   input wire logic [15:0] rd_data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {cmd_valid, wr_valid, rd_take} = 3'h0;
      cmd_code = 8'h00;
      wr_data = 16'h0000;
   end
   task automatic cmd(input logic [7:0] c);
      cmd_code = c;
      cmd_valid = 1'b1;
      @(posedge clk) #1;
      cmd_valid = 1'b0;
      cmd_code = ~c;
   endtask
   task automatic wr(input logic [15:0] d);
      wr_data = d;
      wr_valid = 1'b1;
      @(posedge clk) #1;
      wr_valid = 1'b0;
      wr_data = ~d;
   endtask
   // Word is settled two edges after command or take
   task automatic rd(output logic [15:0] d);
      repeat (2) @(posedge clk);
      #1 d = rd_data;
      rd_take = 1'b1;
      @(posedge clk) #1;
      rd_take = 1'b0;
   endtask
   task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
      cmd(c);
      wr(d);
   endtask
   task automatic rd_reg(input logic [7:0] c, output logic [15:0] d);
      cmd(c);
      rd(d);
   endtask
   // Top byte written as zero; strobe held over both words
   task automatic wr_mask(input logic [31:0] m);
      cmd(8'hc2);
      wr_data = m[15:0];
      wr_valid = 1'b1;
      @(posedge clk) #1;
      wr_data = {8'h00, m[23:16]};
      @(posedge clk) #1;
      wr_valid = 1'b0;
      wr_data = ~wr_data;
   endtask
   task automatic rd_mask(output logic [31:0] m);
      cmd(8'hc3);
      rd(m[15:0]);
      rd(m[31:16]);
   endtask
endmodule

/* File: verification/tb_usb_dev_irq_enable_dma_config.sv */
// Purpose: self-checking bench for udcfg_regs
// Assumes: host model drives the command port
// Notes: events, byte steps and bus reset come from here
`include "udcfg_consts.svh"
module tb_usb_dev_irq_enable_dma_config;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rstn = 1'b0, usb_bus_reset = 1'b0, count_step = 1'b0, short_out_packet = 1'b0;
   logic [23:0] event_pulse = 24'h0, event_status;
   logic cmd_valid, wr_valid, rd_take, irq_req, dma_active, end_of_transfer;
   logic [7:0] cmd_code;
   logic [15:0] wr_data, rd_data, v, got;
   logic [31:0] m, g;
   logic [3:0] dma_target_endpoint;
   logic [1:0] burst_length_sel;
   int failures = 0, n_checks = 0, eots = 0, e0, cycles = 0, seed = 32'h3520;
   always #2.5 clk = ~clk;
   udcfg_regs dut_u (.clk, .rstn, .cmd_valid, .cmd_code, .wr_valid, .wr_data, .rd_take, .rd_data,
      .usb_bus_reset, .event_pulse, .count_step, .short_out_packet, .irq_req, .event_status,
      .dma_active, .dma_target_endpoint, .burst_length_sel, .end_of_transfer);
   udcfg_host host_u (.clk, .cmd_valid, .cmd_code, .wr_valid, .wr_data, .rd_take, .rd_data);
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Expected register images, worked out from the field masks
   function automatic logic [15:0] exp_setup(input logic [15:0] w);
      return w & `UDCFG_SETUP_WMASK;
   endfunction
   function automatic logic [31:0] exp_mask(input logic [31:0] w);
      return w & `UDCFG_MASK_WMASK;
   endfunction
   // Bus reset drops only the run bit
   function automatic logic [15:0] exp_bus_reset(input logic [15:0] s);
      return s & ~(16'h0001 << `UDCFG_BIT_RUN);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (failures == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Pulse counter and hang guard; whole run is about 600 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (end_of_transfer === 1'b1) eots <= eots + 1;
      if (cycles == 20000) begin
         failures++;
         end_of_test();
      end
   end
   initial begin
      tick(16);
      rstn = 1'b1;
      tick(3);
      host_u.rd_reg(`UDCFG_CMD_SETUP_RD, got);
      check(got, `UDCFG_SETUP_RESET);
      host_u.rd_mask(g);
      check(g, `UDCFG_MASK_RESET);
      // Random fields, every burst code; count end kept off
      for (int i = 0; i < 8; i++) begin
         v = 16'($random(seed));
         v[1:0] = i[1:0];
         v[15:14] = 2'b00;
         host_u.wr_reg(`UDCFG_CMD_SETUP_WR, v);
         tick(2);
         host_u.rd_reg(`UDCFG_CMD_SETUP_RD, got);
         check(got, exp_setup(v));
         check(dma_active, v[3]);
         check(dma_target_endpoint, v[7:4]);
         check(burst_length_sel, v[1:0]);
      end
      m = $random(seed);
      host_u.wr_mask(m);
      host_u.rd_mask(g);
      check(g, exp_mask(m));
      // Each enable gates only the request
      for (int k = 0; k < 24; k++) begin
         if (k == 7) continue;
         host_u.wr_mask(~(32'h1 << k));
         host_u.rd_mask(g);
         check(g, exp_mask(~(32'h1 << k)));
         event_pulse[k] = 1'b1;
         tick(1);
         event_pulse = 24'h0;
         tick(2);
         check(irq_req, 1'b0);
         check(event_status, 24'h1 << k);
         host_u.wr_mask(32'h1 << k);
         tick(3);
         check(irq_req, 1'b1);
      end
      host_u.wr_reg(`UDCFG_CMD_SETUP_WR, 16'h40b9);
      tick(3);
      usb_bus_reset = 1'b1;
      tick(1);
      usb_bus_reset = 1'b0;
      tick(2);
      check(dma_active, 1'b0);
      host_u.rd_reg(`UDCFG_CMD_SETUP_RD, got);
      check(got, exp_bus_reset(exp_setup(16'h40b9)));
      e0 = eots;
      host_u.wr_reg(`UDCFG_CMD_COUNT_WR, 16'h0003);
      host_u.wr_reg(`UDCFG_CMD_SETUP_WR, 16'h8008);
      tick(2);
      count_step = 1'b1;
      tick(1);
      count_step = 1'b0;
      host_u.rd_reg(`UDCFG_CMD_COUNT_RD, got);
      check(got, 16'h0002);
      count_step = 1'b1;
      tick(2);
      count_step = 1'b0;
      tick(2);
      check(eots - e0, 1);
      check(dma_active, 1'b0);
      host_u.wr_reg(`UDCFG_CMD_SETUP_WR, 16'h8008);
      tick(2);
      host_u.rd_reg(`UDCFG_CMD_COUNT_RD, got);
      check(got, 16'h0003);
      // Short mode only with an OUT target
      e0 = eots;
      host_u.wr_reg(`UDCFG_CMD_SETUP_WR, 16'h4028);
      tick(2);
      short_out_packet = 1'b1;
      tick(1);
      short_out_packet = 1'b0;
      tick(2);
      check(eots - e0, 1);
      check(dma_active, 1'b0);
      host_u.wr_reg(`UDCFG_CMD_SETUP_WR, 16'h0008);
      tick(2);
      check(dma_active, 1'b1);
      host_u.wr_reg(`UDCFG_CMD_SETUP_WR, 16'h0000);
      tick(2);
      check(dma_active, 1'b0);
      end_of_test();
   end
endmodule
